// ### include/i2c_seq_pkg.sv
package i2c_seq_pkg;

    // =====================================================
    // register map (byte addresses)
    localparam logic [7:0] ctrl_addr   = 8'h00;
    localparam logic [7:0] status_addr = 8'h04;
    localparam logic [7:0] reload_addr = 8'h08;
    localparam logic [7:0] buf_addr    = 8'h0c;

    // =====================================================
    // control field positions
    localparam int unit_en_bit    = 0;
    localparam int start_bit      = 1;
    localparam int stop_bit       = 2;
    localparam int ack_bit        = 3;
    localparam int ack_data_bit   = 4;

    // =====================================================
    // status field positions (write one to clear for event, coll and write_collision_flag)
    localparam int start_seen_bit = 0;
    localparam int stop_seen_bit  = 1;
    localparam int event_bit      = 2;
    localparam int coll_bit       = 3;
    localparam int write_collision_flag_bit       = 4;
    localparam int full_bit       = 5;
    localparam int busy_bit       = 6;
    localparam int ev_en_bit      = 7;

    // =====================================================
    // reset values
    localparam logic [7:0] reload_rst = 8'h13;
    localparam logic [7:0] ctrl_rst   = 8'h00;

    typedef struct packed {
        logic scl;
        logic sda;
    } lines_t;

    typedef enum logic [3:0] {
        st_idle,
        st_start_wait,
        st_start_hold,
        st_ack_low,
        st_ack_high,
        st_ack_end,
        st_stop_wait,
        st_stop_cnt,
        st_stop_rel,
        st_stop_chk,
        st_stop_end
    } seq_t;

endpackage

// ### hdl/i2c_seq.sv
`timescale 1ns/1ns
module i2c_seq
    import i2c_seq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);

    // =====================================================
    // pin synchronisers
    lines_t meta_r;
    lines_t pin_r;
    lines_t prev_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '{scl: 1'b1, sda: 1'b1};
            pin_r  <= '{scl: 1'b1, sda: 1'b1};
            prev_r <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            meta_r <= '{scl: scl_i, sda: sda_i};
            pin_r  <= meta_r;
            prev_r <= pin_r;
        end
    end

    logic bus_start;
    logic bus_stop;
    assign bus_start = pin_r.scl && prev_r.sda && !pin_r.sda;
    assign bus_stop  = pin_r.scl && !prev_r.sda && pin_r.sda;

    // =====================================================
    // apb decode
    logic wr;
    logic rd_any;
    assign wr      = psel && penable && pwrite;
    assign rd_any  = psel && penable;
    assign pready  = 1'b1;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    logic mapped;
    assign mapped = hit(paddr, ctrl_addr) || hit(paddr, status_addr) ||
                    hit(paddr, reload_addr) || hit(paddr, buf_addr);
    assign pslverr = rd_any && !mapped;

    // =====================================================
    // state and registers
    seq_t       state_r;
    logic       unit_en_r;
    logic       start_en_r;
    logic       stop_en_r;
    logic       ack_en_r;
    logic       ack_data_r;
    logic       ev_en_r;
    logic [7:0] reload_r;
    logic [7:0] buf_r;
    logic [7:0] cnt_r;
    logic       cnt_run_r;
    logic       start_seen_r;
    logic       stop_seen_r;
    logic       event_r;
    logic       coll_r;
    logic       write_collision_flag_r;
    logic       full_r;
    logic [3:0] bit_idx_r;
    logic       scl_low_r;
    logic       sda_low_r;

    logic in_seq;
    assign in_seq = state_r != st_idle;

    logic buf_wr;
    assign buf_wr = wr && hit(paddr, buf_addr);
    logic ctrl_wr;
    assign ctrl_wr = wr && hit(paddr, ctrl_addr);
    logic stat_wr;
    assign stat_wr = wr && hit(paddr, status_addr);

    // =====================================================
    // baud counter
    logic tick;
    logic load;
    logic halt;
    assign tick = cnt_run_r && (cnt_r == 8'h00);

    always_ff @(posedge clk) begin
        if (rst || halt) begin
            cnt_r     <= 8'h00;
            cnt_run_r <= 1'b0;
        end else if (load || tick) begin
            cnt_r     <= reload_r;
            cnt_run_r <= 1'b1;
        end else if (cnt_run_r) begin
            cnt_r     <= cnt_r - 8'h01;
        end
    end

    // =====================================================
    // sequencer
    logic coll;
    logic done_ack;
    logic done_stop;
    logic stop_seen_set;

    always_comb begin
        load          = 1'b0;
        halt          = 1'b0;
        coll          = 1'b0;
        done_ack      = 1'b0;
        done_stop     = 1'b0;
        stop_seen_set = 1'b0;
        case (state_r)
            st_idle: begin
                halt = 1'b1;
            end
            st_start_wait: begin
                if (!cnt_run_r) begin
                    if (!pin_r.sda || !pin_r.scl)
                        coll = 1'b1;
                    else
                        load = 1'b1;
                end else if (!pin_r.sda) begin
                    load = 1'b1;
                end else if (!pin_r.scl) begin
                    coll = 1'b1;
                end
            end
            st_ack_low: begin
                if (!cnt_run_r)
                    load = 1'b1;
                // stop at release so the high half waits for the pin
                if (tick)
                    halt = 1'b1;
            end
            st_ack_high: begin
                if (!cnt_run_r && pin_r.scl)
                    load = 1'b1;
                if (!sda_low_r && !pin_r.sda && pin_r.scl)
                    coll = 1'b1;
            end
            st_stop_wait: begin
                if (!pin_r.sda)
                    load = 1'b1;
            end
            st_stop_chk: begin
                if (pin_r.sda && pin_r.scl)
                    stop_seen_set = 1'b1;
            end
            default: begin
            end
        endcase
        if (coll)
            halt = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst || !unit_en_r) begin
            state_r   <= st_idle;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
            bit_idx_r <= 4'h0;
        end else if (coll) begin
            state_r   <= st_idle;
            scl_low_r <= 1'b0;
            sda_low_r <= 1'b0;
        end else begin
            case (state_r)
                st_idle: begin
                    if (start_en_r) begin
                        state_r   <= st_start_wait;
                        scl_low_r <= 1'b0;
                        sda_low_r <= 1'b0;
                    end else if (ack_en_r) begin
                        state_r   <= st_ack_low;
                        scl_low_r <= 1'b1;
                        sda_low_r <= !ack_data_r;
                    end else if (stop_en_r) begin
                        state_r   <= st_stop_wait;
                        scl_low_r <= 1'b1;
                        sda_low_r <= 1'b1;
                    end
                    if (buf_wr && !in_seq)
                        bit_idx_r <= 4'h0;
                end
                st_start_wait: begin
                    if (cnt_run_r && (tick || !pin_r.sda)) begin
                        sda_low_r <= 1'b1;
                        state_r   <= st_start_hold;
                    end
                end
                st_start_hold: begin
                    if (tick) begin
                        scl_low_r <= 1'b1;
                        state_r   <= st_idle;
                    end
                end
                st_ack_low: begin
                    if (tick) begin
                        scl_low_r <= 1'b0;
                        state_r   <= st_ack_high;
                    end
                end
                st_ack_high: begin
                    if (cnt_run_r && tick) begin
                        scl_low_r <= 1'b1;
                        state_r   <= st_ack_end;
                    end
                end
                st_ack_end: begin
                    state_r <= st_idle;
                end
                st_stop_wait: begin
                    if (!pin_r.sda)
                        state_r <= st_stop_cnt;
                end
                st_stop_cnt: begin
                    if (tick) begin
                        scl_low_r <= 1'b0;
                        state_r   <= st_stop_rel;
                    end
                end
                st_stop_rel: begin
                    if (tick) begin
                        sda_low_r <= 1'b0;
                        state_r   <= st_stop_chk;
                    end
                end
                st_stop_chk: begin
                    if (pin_r.sda && pin_r.scl)
                        state_r <= st_stop_end;
                end
                st_stop_end: begin
                    if (tick)
                        state_r <= st_idle;
                end
                default: begin
                    state_r <= st_idle;
                end
            endcase
        end
    end

    // =====================================================
    // control bits; hardware clears win
    always_ff @(posedge clk) begin
        if (rst) begin
            unit_en_r  <= 1'b0;
            start_en_r <= 1'b0;
            stop_en_r  <= 1'b0;
            ack_en_r   <= 1'b0;
            ack_data_r <= 1'b0;
            ev_en_r    <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                unit_en_r  <= pwdata[unit_en_bit];
                ack_data_r <= pwdata[ack_data_bit];
                if (!in_seq) begin
                    start_en_r <= pwdata[start_bit];
                    stop_en_r  <= pwdata[stop_bit];
                    ack_en_r   <= pwdata[ack_bit];
                end
            end
            if (stat_wr)
                ev_en_r <= pwdata[ev_en_bit];
            if (coll || !unit_en_r) begin
                start_en_r <= 1'b0;
                stop_en_r  <= 1'b0;
                ack_en_r   <= 1'b0;
            end
            if (state_r == st_start_hold && tick)
                start_en_r <= 1'b0;
            if (state_r == st_ack_end)
                ack_en_r <= 1'b0;
            if (state_r == st_stop_end && tick)
                stop_en_r <= 1'b0;
        end
    end

    // =====================================================
    // status flags; set beats clear
    logic ev_set;
    assign ev_set = (state_r == st_stop_end && tick)
                 || (state_r == st_start_hold && tick)
                 || (state_r == st_ack_end)
                 || (bus_stop && ev_en_r && !in_seq);

    logic write_collision_flag_set;
    assign write_collision_flag_set = buf_wr && in_seq;

    always_ff @(posedge clk) begin
        if (rst || !unit_en_r) begin
            start_seen_r <= 1'b0;
            stop_seen_r  <= 1'b0;
        end else begin
            if (bus_start) begin
                start_seen_r <= 1'b1;
                stop_seen_r  <= 1'b0;
            end
            if (bus_stop || stop_seen_set) begin
                stop_seen_r  <= 1'b1;
                start_seen_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            event_r <= 1'b0;
            coll_r  <= 1'b0;
            write_collision_flag_r  <= 1'b0;
        end else begin
            if (stat_wr && pwdata[event_bit])
                event_r <= 1'b0;
            if (stat_wr && pwdata[coll_bit])
                coll_r <= 1'b0;
            if (stat_wr && pwdata[write_collision_flag_bit])
                write_collision_flag_r <= 1'b0;
            if (ev_set)
                event_r <= 1'b1;
            if (coll)
                coll_r <= 1'b1;
            if (write_collision_flag_set)
                write_collision_flag_r <= 1'b1;
        end
    end

    // =====================================================
    // shift buffer: no byte engine here, so full just marks a load
    always_ff @(posedge clk) begin
        if (rst) begin
            buf_r  <= 8'h00;
            full_r <= 1'b0;
        end else if (coll) begin
            full_r <= 1'b0;
        end else if (buf_wr && !in_seq) begin
            buf_r  <= pwdata[7:0];
            full_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            reload_r <= reload_rst;
        else if (wr && hit(paddr, reload_addr))
            reload_r <= pwdata[7:0];
    end

    // =====================================================
    // read mux
    logic [7:0] stat_v;
    always_comb begin
        stat_v                 = 8'h00;
        stat_v[start_seen_bit] = start_seen_r;
        stat_v[stop_seen_bit]  = stop_seen_r;
        stat_v[event_bit]      = event_r;
        stat_v[coll_bit]       = coll_r;
        stat_v[write_collision_flag_bit]       = write_collision_flag_r;
        stat_v[full_bit]       = full_r;
        stat_v[busy_bit]       = in_seq;
        stat_v[ev_en_bit]      = ev_en_r;
    end

    logic [7:0] ctrl_v;
    always_comb begin
        ctrl_v               = ctrl_rst;
        ctrl_v[unit_en_bit]  = unit_en_r;
        ctrl_v[start_bit]    = start_en_r;
        ctrl_v[stop_bit]     = stop_en_r;
        ctrl_v[ack_bit]      = ack_en_r;
        ctrl_v[ack_data_bit] = ack_data_r;
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_any && !pwrite) begin
            if (hit(paddr, ctrl_addr))
                prdata = {24'h00_0000, ctrl_v};
            else if (hit(paddr, status_addr))
                prdata = {24'h00_0000, stat_v};
            else if (hit(paddr, reload_addr))
                prdata = {24'h00_0000, reload_r};
            else if (hit(paddr, buf_addr))
                prdata = {24'h00_0000, buf_r};
        end
    end

    // =====================================================
    // open-drain pins: only ever pull low
    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = scl_low_r;
    assign sda_oe = sda_low_r;

endmodule

// ### tb/i2c_bus_model.sv
`timescale 1ns/1ns
// =====================================================
// far side: pull-ups plus one other master on the wires
module i2c_bus_model (
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    input  wire logic scl_hold,
    input  wire logic sda_hold,
    input  wire logic gen_stop,
    output logic      scl_i,
    output logic      sda_i
);
    logic g_scl;
    logic g_sda;

    initial begin
        g_scl = 1'b0;
        g_sda = 1'b0;
    end

    // wired-and: any party pulling low wins, else pull-up
    assign scl_i = !(scl_oe || scl_hold || g_scl);
    assign sda_i = !(sda_oe || sda_hold || g_sda);

    // other master: start then stop, 160 ns link clock
    // only launched by the bench while the bus is free
    always @(posedge gen_stop) begin
        g_sda = 1'b1;
        #80 g_scl = 1'b1;
        #80 g_scl = 1'b0;
        #80 g_sda = 1'b0;
    end
endmodule

// ### tb/i2c_seq_monitor.sv
`timescale 1ns/1ns
// =====================================================
// port checker
module i2c_seq_monitor
    import i2c_seq_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scl_i,
    input wire logic        scl_o,
    input wire logic        scl_oe,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic       off_r;
    logic [7:0] rl_r;
    wire acc    = psel && penable;
    wire rd_acc = acc && !pwrite;
    wire mapped = paddr inside {ctrl_addr, status_addr, reload_addr, buf_addr};
    wire wr_ctl = acc && pwrite && paddr == ctrl_addr && pwdata[unit_en_bit];
    wire wr_ack = wr_ctl && pwdata[ack_bit] && !pwdata[start_bit];
    wire wr_stp = wr_ctl && pwdata[stop_bit] && !pwdata[start_bit];

    // shadow of the enable; disabled out of reset
    always_ff @(posedge clk) begin
        if (rst)
            off_r <= 1'b1;
        else if (acc && pwrite && paddr == ctrl_addr)
            off_r <= !pwdata[unit_en_bit];
    end
    always_ff @(posedge clk) begin
        if (rst)
            rl_r <= reload_rst;
        else if (acc && pwrite && paddr == reload_addr)
            rl_r <= pwdata[7:0];
    end

    property p_lines_low;
        scl_o == 1'b0 && sda_o == 1'b0;
    endproperty
    a_lines_low: assert property (p_lines_low)
        else $error("line driven high");
    property p_rst_rel;
        @(posedge clk) disable iff (1'b0) rst |=> !scl_oe && !sda_oe;
    endproperty
    a_rst_rel: assert property (p_rst_rel)
        else $error("lines held through reset");
    property p_ready;
        acc |-> pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("wait state inserted");
    property p_err;
        acc |-> pslverr == !mapped;
    endproperty
    a_err: assert property (p_err)
        else $error("slave error mismatch");
    property p_off_flags;
        rd_acc && paddr == status_addr && off_r
            |-> prdata[stop_seen_bit:start_seen_bit] == 2'b00;
    endproperty
    a_off_flags: assert property (p_off_flags)
        else $error("seen flags set while disabled");
    property p_reload;
        rd_acc && paddr == reload_addr |-> prdata[7:0] == rl_r;
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload readback wrong");
    property p_ack_drive;
        wr_ack && !off_r
            |=> ##1 scl_oe && sda_oe != $past(pwdata[ack_data_bit], 2);
    endproperty
    a_ack_drive: assert property (p_ack_drive)
        else $error("ack sequence drive wrong");
    property p_stop_drive;
        wr_stp |-> ##[1:4] sda_oe;
    endproperty
    a_stop_drive: assert property (p_stop_drive)
        else $error("stop did not pull data low");

    c_ack: cover property (wr_ack);
    c_stop: cover property (wr_stp);
    c_coll: cover property (rd_acc && paddr == status_addr && prdata[coll_bit]);
endmodule

// ### tb/test_i2c_seq.sv
`timescale 1ns/1ns
// =====================================================
// bench top
module test_i2c_seq
    import i2c_seq_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe;
    logic        scl_i, sda_i, scl_hold, sda_hold, gen_stop;
    int          miscompares, cmp_count, seed, rl, n, dv, bm;

    i2c_seq uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
    i2c_bus_model bus (.scl_oe(scl_oe), .sda_oe(sda_oe),
        .scl_hold(scl_hold), .sda_hold(sda_hold), .gen_stop(gen_stop),
        .scl_i(scl_i), .sda_i(sda_i));

    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        if (k >= 50)
            chk(0, 1, "apb hang");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input int m, input int e, input string s);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e, s);
    endtask
    function logic sg(input int c);
        return c == 0 ? sda_oe : c == 1 ? scl_oe : scl_i;
    endfunction
    // level wait; n returns the cycles spent
    task wt(input int c, input logic v);
        n = 0;
        while (sg(c) !== v && n < 900) begin
            @(posedge clk);
            n++;
        end
        if (n >= 900)
            chk(0, 1, "line wait hang");
    endtask
    task rng(input int v, input int lo, input int hi, input string s);
        chk(v >= lo && v <= hi, 1, s);
    endtask
    task clr;
        apb(1'b1, status_addr, 32'h1c);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #2000000;
        miscompares++;
        summarize;
    end

    initial begin
        {psel, penable, pwrite, scl_hold, sda_hold, gen_stop} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst = 1'b1;
        seed = 23;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc(ctrl_addr, 'hff, ctrl_rst, "ctrl reset");
        rdc(reload_addr, 'hff, reload_rst, "reload reset");
        apb(1'b0, 8'h10, 32'h0);
        chk(err, 1, "unmapped error");
        rl = 3 + ($unsigned($random(seed)) % 6);
        bm = $unsigned($random(seed)) & 'hff;
        apb(1'b1, reload_addr, rl);
        rdc(reload_addr, 'hff, rl, "reload rw");
        apb(1'b1, ctrl_addr, 32'h01);
        $display("registers done");
        // start with data already low, then clock pulled mid-count
        for (int i = 0; i < 2; i++) begin
            if (i == 0)
                sda_hold <= 1'b1;
            apb(1'b1, ctrl_addr, 32'h03);
            scl_hold <= (i == 1);
            repeat (rl + 8) @(posedge clk);
            chk({scl_oe, sda_oe}, 0, "lines after start fault");
            {scl_hold, sda_hold} <= 2'b00;
            rdc(status_addr, 'h08, 'h08, "start collision");
            rdc(ctrl_addr, 'h02, 0, "start enable cleared");
            clr;
        end
        // other master pulls data during the count
        apb(1'b1, ctrl_addr, 32'h03);
        sda_hold <= 1'b1;
        wt(0, 1);
        rng(n, 2, 5, "early data drive");
        sda_hold <= 1'b0;
        wt(1, 1);
        rdc(status_addr, 'h08, 0, "no collision on early drive");
        apb(1'b1, buf_addr, bm);
        rdc(buf_addr, 'hff, bm, "buffer store");
        clr;
        $display("start faults done");
        for (dv = 0; dv < 3; dv++) begin
            // except in the collision pass (dv 2), hold the clock before release so no short high slips in
            scl_hold <= (dv != 2);
            apb(1'b1, ctrl_addr, 32'h09 | ((dv != 0) << ack_data_bit));
            repeat (2) @(posedge clk);
            chk({scl_oe, sda_oe}, {1'b1, dv == 0}, "ack drive");
            wt(1, 0);
            rng(n, rl + 1, rl + 2, "ack low time");
            if (dv == 2) begin
                wt(2, 1);
                sda_hold <= 1'b1;
                repeat (8) @(posedge clk);
                chk({scl_oe, sda_oe}, 0, "ack collision release");
                sda_hold <= 1'b0;
                rdc(status_addr, 'h28, 'h08, "collision flags");
            end else begin
                apb(1'b1, buf_addr, ~bm);
                repeat (20) @(posedge clk);
                scl_hold <= 1'b0;
                wt(2, 1);
                wt(1, 1);
                rng(n, rl, rl + 4, "ack high time");
                rdc(status_addr, 'h14, 'h14, "ack event and write_collision_flag");
                rdc(buf_addr, 'hff, bm, "buffer kept");
            end
            rdc(ctrl_addr, 'h08, 0, "ack enable cleared");
            clr;
        end
        $display("ack done");
        apb(1'b1, ctrl_addr, 32'h05);
        apb(1'b1, buf_addr, ~bm);
        wt(0, 1);
        wt(0, 0);
        chk(scl_oe, 0, "clock released before data");
        repeat (2 * rl + 12) @(posedge clk);
        rdc(ctrl_addr, 'h04, 0, "stop enable cleared");
        rdc(status_addr, 'h16, 'h16, "stop flags");
        rdc(buf_addr, 'hff, bm, "stop buffer kept");
        clr;
        $display("stop done");
        apb(1'b1, ctrl_addr, 32'h03);
        wt(0, 1);
        chk(scl_oe, 0, "data low before clock");
        wt(1, 1);
        rdc(status_addr, 'h0c, 'h04, "start event");
        apb(1'b1, ctrl_addr, 32'h00);
        repeat (2) @(posedge clk);
        chk({scl_oe, sda_oe}, 0, "disable releases");
        rdc(status_addr, 'h03, 0, "seen flags cleared");
        apb(1'b1, ctrl_addr, 32'h01);
        apb(1'b1, status_addr, 32'h9c);
        gen_stop <= 1'b1;
        repeat (60) @(posedge clk);
        gen_stop <= 1'b0;
        rdc(status_addr, 'h04, 'h04, "bus stop event");
        $display("bus monitor done");
        summarize;
    end
endmodule

bind i2c_seq i2c_seq_monitor mon (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_i),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe));
